/* File: core/gpr_map.svh */
// Register offsets, field positions and reset values of the GPIO port
`ifndef GPR_MAP_SVH
`define GPR_MAP_SVH
`define GPR_DIR_OFS      8'h00
`define GPR_DIRECTION_SET_ALIAS_OFS   8'h04
`define GPR_DIRECTION_CLEAR_ALIAS_OFS   8'h08
`define GPR_DIRECTION_TOGGLE_ALIAS_OFS   8'h0c
`define GPR_LVL_OFS      8'h10
`define GPR_LVLSET_OFS   8'h14
`define GPR_LVLCLR_OFS   8'h18
`define GPR_LVLTGL_OFS   8'h1c
`define GPR_IN_OFS       8'h20
`define GPR_ICTL_OFS     8'h24
`define GPR_I0SEL_OFS    8'h28
`define GPR_I1SEL_OFS    8'h2c
`define GPR_PEND_OFS     8'h30
`define GPR_RELOC_OFS    8'h34
`define GPR_MPC_OFS      8'h38
`define GPR_CFG_BASE     3'b010
`define GPR_VP_BASE      8'h60
`define GPR_VP_END       8'ha0
`define GPR_CFG_SLEW     7
`define GPR_CFG_INV      6
`define GPR_OPC_HI       5
`define GPR_OPC_LO       3
`define GPR_ISC_HI       2
`define GPR_ISC_LO       0
`define GPR_OPC_PULLDN   3'b010
`define GPR_OPC_PULLUP   3'b011
`define GPR_OPC_HOLD     3'b001
`define GPR_ISC_BOTH     3'b000
`define GPR_ISC_RISE     3'b001
`define GPR_ISC_FALL     3'b010
`define GPR_ISC_LOW      3'b011
`define GPR_ISC_OFF      3'b111
`define GPR_RST_BYTE     8'h00
`define GPR_RELOC_SPI    5
`define GPR_RELOC_SER    4
`endif

/* File: core/gpr_pkg.sv */
// Types shared by the GPIO port
package gpr_pkg;
   typedef logic [7:0] gpr_byte_t;
   typedef logic [3:0] gpr_nib_t;
   typedef struct packed {
      gpr_byte_t        dir;
      gpr_byte_t        lvl;
      gpr_byte_t        i0sel;
      gpr_byte_t        i1sel;
      logic [3:0]       ictl;
      logic [1:0]       flg;
      logic [5:0]       reloc;
      gpr_byte_t        mpc;
      logic [7:0][7:0]  cfg;
      gpr_byte_t        s1;
      gpr_byte_t        s2;
      gpr_byte_t        prev;
      logic             pend;
      logic             pwr;
      logic             hit;
      gpr_byte_t        paddr;
      logic             ready;
      gpr_byte_t        rdata;
      gpr_byte_t        pout;
      gpr_byte_t        poe;
      gpr_byte_t        pup;
      gpr_byte_t        pdn;
      gpr_byte_t        phold;
      gpr_byte_t        pslew;
      gpr_nib_t         ser_in;
      logic [1:0]       irq;
   } gpr_state_s;
endpackage

/* File: core/gpr_port.sv */
// GPIO port: AHB-Lite registers, pin drivers, pin interrupts, remap
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`include "gpr_map.svh"
// Operation
// - Direction bit one makes pin output, zero makes it input
// - Direction set/clear/toggle aliases change only bits written one
// - Reading any direction alias returns the direction register
// - Level bit drives pin high or low while direction is output
// - Level set/clear/toggle aliases change only bits written one
// - Reading any level alias returns the level register
// - Input bit follows pin; reads zero while input buffer disabled
// - Interrupt control holds two 2-bit enable/priority fields
// - Pin feeds interrupt 0 only when selected; sense from pin config
// - Pin feeds interrupt 1 only when selected; selects independent
// - Pending flags set on sense match, cleared by writing one
// - Relocate register upper two bits reserved, read zero
// - Relocate bit 5 swaps serial clock and data-out pins
// - Relocate bit 4 moves serial unit from low to high nibble
// - Bits 3 and 2 move compare D to pin 7, C to pin 6
// - Bit 1 moves compare B to pin 5, ORed with timer 1
// - Bit 0 moves compare A to pin 4, ORed with timer 1
// - Config bit 7 enables pin slew limiting
// - Config bit 6 inverts pin output and input data
// - Config bits 5:3 select push-pull, hold, pulls, wired-OR and wired-AND
// - Multi-pin mask spreads one config write to all masked pins
// - Four virtual port windows act exactly like the real registers
// - Multi-pin mask clears itself after any config write
// - Sense field: both, rising, falling, low level, or input off
// - Wired-OR drives high only when level and direction are one
// - Wired-AND drives low only when level zero and output
module gpr_port (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              ce,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire gpr_pkg::gpr_byte_t pin_in,
   output gpr_pkg::gpr_byte_t     pin_out,
   output gpr_pkg::gpr_byte_t     pin_oe,
   output gpr_pkg::gpr_byte_t     pin_pull_up,
   output gpr_pkg::gpr_byte_t     pin_pull_down,
   output gpr_pkg::gpr_byte_t     pin_hold,
   output gpr_pkg::gpr_byte_t     pin_slew_limit,
   input  wire gpr_pkg::gpr_nib_t timer0_compare_out,
   input  wire gpr_pkg::gpr_nib_t timer0_compare_en,
   input  wire logic [1:0]        timer1_compare_out,
   input  wire logic [1:0]        timer1_compare_en,
   input  wire gpr_pkg::gpr_nib_t serial_out,
   input  wire gpr_pkg::gpr_nib_t serial_oe,
   output gpr_pkg::gpr_nib_t      serial_in,
   output logic                   irq0_req,
   output logic                   irq1_req,
   output logic [1:0]             irq0_priority,
   output logic [1:0]             irq1_priority
);
   import gpr_pkg::*;

   gpr_state_s st;
   gpr_state_s next_st;
   gpr_byte_t  nadr;
   gpr_byte_t  wd;
   gpr_byte_t  rd;
   gpr_byte_t  vin;
   gpr_byte_t  match;
   gpr_byte_t  tim_en;
   gpr_byte_t  tim_v;
   gpr_byte_t  ser_en;
   gpr_byte_t  ser_v;
   gpr_nib_t   sw_o;
   gpr_nib_t   sw_e;
   gpr_nib_t   nib;
   gpr_nib_t   t0_lo;
   gpr_nib_t   t0_hi;
   logic [1:0] clr;
   logic [1:0] set;
   logic [2:0] output_pull_config;
   logic [2:0] sense_select;
   logic       ov;
   logic       od;
   logic       lv;
   logic       act;
   logic       wr;

   assign wd  = hwdata[7:0];
   assign act = st.pend & ce;
   assign wr  = act & st.pwr & st.hit;

   // -------------------------------------------------------------
   // Address normalisation
   // -------------------------------------------------------------
   // Virtual windows fold onto direction, level, input and pending
   always_comb begin
      nadr = st.paddr;
      if ((st.paddr >= `GPR_VP_BASE) && (st.paddr < `GPR_VP_END)) begin
         case (st.paddr[3:2])
            2'h0:    nadr = `GPR_DIR_OFS;
            2'h1:    nadr = `GPR_LVL_OFS;
            2'h2:    nadr = `GPR_IN_OFS;
            default: nadr = `GPR_PEND_OFS;
         endcase
      end
   end

   // -------------------------------------------------------------
   // Input sensing
   // -------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         sense_select = st.cfg[i][`GPR_ISC_HI:`GPR_ISC_LO];
         // Disabled buffer reads zero and never senses
         vin[i] = (sense_select == `GPR_ISC_OFF) ? 1'b0 : st.s2[i] ^ st.cfg[i][`GPR_CFG_INV];
         case (sense_select)
            `GPR_ISC_BOTH: match[i] = vin[i] ^ st.prev[i];
            `GPR_ISC_RISE: match[i] = vin[i] & ~st.prev[i];
            `GPR_ISC_FALL: match[i] = ~vin[i] & st.prev[i];
            `GPR_ISC_LOW:  match[i] = ~vin[i];
            default:       match[i] = 1'b0;
         endcase
      end
      set[0] = |(match & st.i0sel);
      set[1] = |(match & st.i1sel);
   end

   // -------------------------------------------------------------
   // Peripheral overrides
   // -------------------------------------------------------------
   always_comb begin
      t0_lo  = timer0_compare_en & ~st.reloc[3:0];
      t0_hi  = timer0_compare_en & st.reloc[3:0];
      tim_en = {t0_hi | {2'b00, timer1_compare_en}, t0_lo};
      // Shared pins OR both timers' waveforms
      tim_v  = {(timer0_compare_out & t0_hi) |
                {2'b00, timer1_compare_out & timer1_compare_en},
                timer0_compare_out & t0_lo};
      sw_o = serial_out;
      sw_e = serial_oe;
      nib  = st.reloc[`GPR_RELOC_SER] ? vin[7:4] : vin[3:0];
      if (st.reloc[`GPR_RELOC_SPI]) begin
         sw_o = {serial_out[1], serial_out[2], serial_out[3], serial_out[0]};
         sw_e = {serial_oe[1], serial_oe[2], serial_oe[3], serial_oe[0]};
         nib  = {nib[1], nib[2], nib[3], nib[0]};
      end
      if (st.reloc[`GPR_RELOC_SER]) begin
         ser_en = {sw_e, 4'h0};
         ser_v  = {sw_o, 4'h0};
      end else begin
         ser_en = {4'h0, sw_e};
         ser_v  = {4'h0, sw_o};
      end
   end

   // -------------------------------------------------------------
   // Register read mux
   // -------------------------------------------------------------
   always_comb begin
      rd = `GPR_RST_BYTE;
      if (st.hit) begin
         case (nadr)
            `GPR_DIR_OFS, `GPR_DIRECTION_SET_ALIAS_OFS,
            `GPR_DIRECTION_CLEAR_ALIAS_OFS, `GPR_DIRECTION_TOGGLE_ALIAS_OFS: rd = st.dir;
            `GPR_LVL_OFS, `GPR_LVLSET_OFS,
            `GPR_LVLCLR_OFS, `GPR_LVLTGL_OFS: rd = st.lvl;
            `GPR_IN_OFS:    rd = vin;
            `GPR_ICTL_OFS:  rd = {4'h0, st.ictl};
            `GPR_I0SEL_OFS: rd = st.i0sel;
            `GPR_I1SEL_OFS: rd = st.i1sel;
            `GPR_PEND_OFS:  rd = {6'h00, st.flg};
            `GPR_RELOC_OFS: rd = {2'b00, st.reloc};
            `GPR_MPC_OFS:   rd = st.mpc;
            default: begin
               if (nadr[7:5] == `GPR_CFG_BASE) begin
                  rd = st.cfg[nadr[4:2]];
               end
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb begin
      next_st = st;
      clr     = 2'b00;
      next_st.s1   = pin_in;
      next_st.s2   = st.s1;
      next_st.prev = vin;
      if (st.pend) begin
         next_st.pend  = 1'b0;
         next_st.ready = 1'b1;
         next_st.rdata = rd;
      end
      if (wr) begin
         case (nadr)
            `GPR_DIR_OFS:    next_st.dir = wd;
            `GPR_DIRECTION_SET_ALIAS_OFS: next_st.dir = st.dir | wd;
            `GPR_DIRECTION_CLEAR_ALIAS_OFS: next_st.dir = st.dir & ~wd;
            `GPR_DIRECTION_TOGGLE_ALIAS_OFS: next_st.dir = st.dir ^ wd;
            `GPR_LVL_OFS:    next_st.lvl = wd;
            `GPR_LVLSET_OFS: next_st.lvl = st.lvl | wd;
            `GPR_LVLCLR_OFS: next_st.lvl = st.lvl & ~wd;
            `GPR_LVLTGL_OFS: next_st.lvl = st.lvl ^ wd;
            `GPR_ICTL_OFS:   next_st.ictl = wd[3:0];
            `GPR_I0SEL_OFS:  next_st.i0sel = wd;
            `GPR_I1SEL_OFS:  next_st.i1sel = wd;
            `GPR_PEND_OFS:   clr = wd[1:0];
            `GPR_RELOC_OFS:  next_st.reloc = wd[5:0];
            `GPR_MPC_OFS:    next_st.mpc = wd;
            default: begin
               if (nadr[7:5] == `GPR_CFG_BASE) begin
                  for (int j = 0; j < 8; j++) begin
                     if ((st.mpc != 8'h00) ? st.mpc[j] : (nadr[4:2] == 3'(j))) begin
                        next_st.cfg[j] = wd;
                     end
                  end
                  next_st.mpc = 8'h00;
               end
            end
         endcase
      end
      // A new match beats a same-cycle clear
      next_st.flg = (st.flg & ~clr) | set;
      next_st.irq[0] = st.flg[0] & (st.ictl[1:0] != 2'b00);
      next_st.irq[1] = st.flg[1] & (st.ictl[3:2] != 2'b00);
      if (hsel && htrans[1] && hready && st.ready) begin
         next_st.pend  = 1'b1;
         next_st.pwr   = hwrite;
         next_st.hit   = (haddr[31:8] == 24'h000000);
         next_st.paddr = haddr[7:0];
         next_st.ready = 1'b0;
      end
      next_st.ser_in = nib;
      for (int i = 0; i < 8; i++) begin
         if (ser_en[i]) begin
            ov = ser_v[i];
            od = 1'b1;
         end else if (tim_en[i]) begin
            ov = tim_v[i];
            od = st.dir[i];
         end else begin
            ov = st.lvl[i];
            od = st.dir[i];
         end
         lv  = ov ^ st.cfg[i][`GPR_CFG_INV];
         output_pull_config = st.cfg[i][`GPR_OPC_HI:`GPR_OPC_LO];
         next_st.pslew[i] = st.cfg[i][`GPR_CFG_SLEW];
         next_st.phold[i] = (output_pull_config == `GPR_OPC_HOLD);
         next_st.pdn[i]   = ((output_pull_config == `GPR_OPC_PULLDN) && !od) || (output_pull_config == 3'b110);
         next_st.pup[i]   = ((output_pull_config == `GPR_OPC_PULLUP) && !od) || (output_pull_config == 3'b111);
         if (!output_pull_config[2]) begin
            next_st.pout[i] = lv;
            next_st.poe[i]  = od;
         end else if (!output_pull_config[0]) begin
            next_st.pout[i] = 1'b1;
            next_st.poe[i]  = od & lv;
         end else begin
            next_st.pout[i] = 1'b0;
            next_st.poe[i]  = od & ~lv;
         end
      end
   end

   // -------------------------------------------------------------
   // State register
   // -------------------------------------------------------------
   // A frozen block holds the bus in wait, but drops a transfer whose address phase ends at the first frozen edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st       <= '0;
         st.ready <= 1'b1;
      end else if (ce) begin
         st <= next_st;
      end else begin
         st.ready <= 1'b0;
      end
   end

   assign hrdata         = {24'h000000, st.rdata};
   assign hreadyout      = st.ready;
   assign hresp          = 1'b0;
   assign pin_out        = st.pout;
   assign pin_oe         = st.poe;
   assign pin_pull_up    = st.pup;
   assign pin_pull_down  = st.pdn;
   assign pin_hold       = st.phold;
   assign pin_slew_limit = st.pslew;
   assign serial_in      = st.ser_in;
   assign irq0_req       = st.irq[0];
   assign irq1_req       = st.irq[1];
   assign irq0_priority  = st.ictl[1:0];
   assign irq1_priority  = st.ictl[3:2];

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   AST_DIR_SET: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr && nadr == `GPR_DIRECTION_SET_ALIAS_OFS) |=> ((st.dir & $past(wd)) == $past(wd)))
      else $error("direction set alias lost a bit");
   AST_DIR_ALIAS_READ: assert property (@(posedge hclk) disable iff (!hresetn)
      (act && !st.pwr && st.hit && nadr == `GPR_DIRECTION_TOGGLE_ALIAS_OFS) |=> (hrdata[7:0] == st.dir))
      else $error("direction alias read differs");
   AST_LVL_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr && nadr == `GPR_LVLCLR_OFS) |=> ((st.lvl & $past(wd)) == 8'h00))
      else $error("level clear alias left a bit set");
   AST_IN_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
      (act && st.hit && nadr == `GPR_IN_OFS && st.cfg[0][2:0] == `GPR_ISC_OFF && ce)
      |=> (hrdata[0] == 1'b0))
      else $error("disabled input read nonzero");
   AST_FLAG_SET: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && set[0]) |=> st.flg[0])
      else $error("pending flag not set on match");
   AST_MPC_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr && nadr[7:5] == `GPR_CFG_BASE) |=> (st.mpc == 8'h00))
      else $error("multi-pin mask not cleared");
   AST_PRIO_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && st.ictl[1:0] == 2'b00) |=> !irq0_req)
      else $error("interrupt raised at priority zero");
   AST_WOR_NO_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && st.cfg[0][5:3] == 3'b100) |=> !(pin_oe[0] && !pin_out[0]))
      else $error("wired-OR pin driven low");

endmodule // gpr_port

/* File: verification/gpr_pad_model.sv */
// Pad model of the circuitry attached to the eight port pins
`timescale 1ns/100ps
module gpr_pad_model (
   input  wire logic       hclk,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pin_pull_up,
   input  wire logic [7:0] pin_pull_down,
   input  wire logic [7:0] ext_drv,
   input  wire logic [7:0] ext_en,
   output logic      [7:0] pad
);
   // A floating pad wanders every cycle so no read of it can match by luck
   logic [7:0] drift = 8'h00;

   always @(posedge hclk) begin
      drift <= ~drift;
   end

   // The port's own driver wins; contention is not modelled
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i])
            pad[i] = pin_out[i];
         else if (ext_en[i])
            pad[i] = ext_drv[i];
         else if (pin_pull_up[i] | pin_pull_down[i])
            pad[i] = pin_pull_up[i];
         else
            pad[i] = drift[i];
      end
   end
endmodule // gpr_pad_model

/* File: verification/gpio_port_regs_remap_test.sv */
// Self-checking bench of the GPIO port: registers, pins, interrupts, relocation
`timescale 1ns/100ps
module gpio_port_regs_remap_test;
   import gpr_pkg::*;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic        hreadyout, hresp, irq0, irq1;
   gpr_byte_t   pin_in, pin_out, pin_oe, pin_pu, pin_pd, pin_hold, pin_slew;
   gpr_byte_t   ext_drv = 8'h00, ext_en = 8'h00;
   gpr_nib_t    t0_out = 4'h0, t0_en = 4'h0, ser_out = 4'h0, ser_oe = 4'h0, ser_in;
   logic [1:0]  t1_out = 2'h0, t1_en = 2'h0, pri0, pri1;
   logic [2:0]  sc [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
   logic [2:0]  ex [6] = '{3'h3, 3'h2, 3'h1, 3'h7, 3'h0, 3'h0};
   logic        oe;
   int          error_cnt = 0, checked = 0, cycles = 0;

   always #12.5 hclk = ~hclk;

   gpr_port gpr_port_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_pull_up(pin_pu), .pin_pull_down(pin_pd), .pin_hold(pin_hold),
      .pin_slew_limit(pin_slew), .timer0_compare_out(t0_out), .timer0_compare_en(t0_en),
      .timer1_compare_out(t1_out), .timer1_compare_en(t1_en), .serial_out(ser_out),
      .serial_oe(ser_oe), .serial_in(ser_in), .irq0_req(irq0), .irq1_req(irq1),
      .irq0_priority(pri0), .irq1_priority(pri1));

   gpr_pad_model gpr_pad_model_inst (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pull_up(pin_pu), .pin_pull_down(pin_pd), .ext_drv(ext_drv), .ext_en(ext_en), .pad(pin_in));

   // ----------------------------------------
   // Bus access and comparison
   // ----------------------------------------
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Single word transfer; waits on the slave, never on a fixed count
   task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(a, 1'b1, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string what);
      xfer(a, 1'b0, 8'h00);
      chk(what, {24'h0, e}, rd);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask

   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      // The input register follows floating pads, so it is skipped here
      for (logic [7:0] a = 8'h00; a < 8'h60; a += 8'h04)
         if (a != 8'h20) rdchk(a, 8'h00, "reset value");
      for (logic [7:0] b = 8'h00; b <= 8'h10; b += 8'h10) begin
         wr(b, 8'ha5);
         wr(b + 8'h04, 8'h0f);
         rdchk(b + 8'h04, 8'haf, "set alias");
         wr(b + 8'h08, 8'h81);
         rdchk(b + 8'h08, 8'h2e, "clear alias");
         wr(b + 8'h0c, 8'hff);
         rdchk(b + 8'h0c, 8'hd1, "toggle alias");
      end
      idle(2);
      chk("pin_oe", 8'hd1, pin_oe);
      chk("pin_out", 8'hd1, pin_out & 8'hd1);
      for (int v = 0; v < 4; v++) begin
         wr(8'h60 + 8'(16 * v), 8'h10 + 8'(v));
         rdchk(8'h00, 8'h10 + 8'(v), "virtual dir");
         rdchk(8'h64 + 8'(16 * v), 8'hd1, "virtual level");
      end
      wr(8'h3c, 8'hff);
      rdchk(8'h3c, 8'h00, "unmapped");
      wr(8'h34, 8'hff);
      rdchk(8'h34, 8'h3f, "relocate");
      chk("hresp", 1'b0, hresp);
      wr(8'h24, 8'hfd);
      idle(2);
      chk("priorities", 4'hd, {pri1, pri0});
      wr(8'h00, 8'h00);
      wr(8'h34, 8'h00);
      ext_en <= 8'hff;
      ext_drv <= 8'h3c;
      idle(6);
      rdchk(8'h20, 8'h3c, "input");
      wr(8'h38, 8'h0c);
      wr(8'h40, 8'h40);
      rdchk(8'h38, 8'h00, "mask");
      rdchk(8'h40, 8'h00, "cfg0");
      rdchk(8'h48, 8'h40, "cfg2");
      rdchk(8'h4c, 8'h40, "cfg3");
      idle(4);
      rdchk(8'h20, 8'h30, "inverted input");
      wr(8'h38, 8'h0c);
      wr(8'h40, 8'h00);
      // Pin 0 rising feeds interrupt 0, pin 1 falling feeds interrupt 1
      wr(8'h28, 8'h01);
      wr(8'h2c, 8'h02);
      wr(8'h40, 8'h01);
      wr(8'h44, 8'h02);
      ext_drv <= 8'h3f;
      idle(6);
      rdchk(8'h30, 8'h01, "pending rise");
      chk("irq", 2'h1, {irq1, irq0});
      ext_drv <= 8'h3c;
      idle(6);
      rdchk(8'h30, 8'h03, "pending fall");
      chk("irq", 2'h3, {irq1, irq0});
      wr(8'h30, 8'h01);
      rdchk(8'h30, 8'h02, "pending clear");
      wr(8'h30, 8'h02);
      wr(8'h24, 8'h00);
      ext_drv <= 8'h3d;
      idle(6);
      rdchk(8'h30, 8'h01, "pending off");
      chk("irq off", 2'h0, {irq1, irq0});
      wr(8'h28, 8'h08);
      ext_drv <= 8'h34;
      for (int k = 0; k < 6; k++) begin
         wr(8'h4c, {5'h0, sc[k]});
         idle(6);
         wr(8'h30, 8'h03);
         rdchk(8'h30, {7'h0, ex[k][2]}, "low sense");
         ext_drv <= 8'h3c;
         idle(6);
         rdchk(8'h30, {7'h0, ex[k][1]}, "rise sense");
         wr(8'h30, 8'h03);
         ext_drv <= 8'h34;
         idle(6);
         rdchk(8'h30, {7'h0, ex[k][0]}, "fall sense");
      end
      ext_drv <= 8'h3c;
      idle(6);
      rdchk(8'h20, 8'h34, "input off");
      wr(8'h4c, 8'h00);
      wr(8'h00, 8'hff);
      wr(8'h10, 8'h00);
      t0_en <= 4'hf;
      t0_out <= 4'h5;
      idle(2);
      chk("timer pins", 8'h05, pin_out);
      wr(8'h34, 8'h0f);
      idle(2);
      chk("timer moved", 8'h50, pin_out);
      // Timer 0 alone drives pin 4 high and timer 1 alone drives pin 5, so the OR sets both
      t0_out <= 4'h1;
      t1_en <= 2'h3;
      t1_out <= 2'h2;
      wr(8'h34, 8'h03);
      idle(2);
      chk("timer or", 8'h30, pin_out);
      t1_en <= 2'h0;
      t0_out <= 4'h5;
      ser_oe <= 4'hf;
      ser_out <= 4'h2;
      wr(8'h34, 8'h10);
      idle(2);
      chk("serial high", 8'h25, pin_out);
      wr(8'h34, 8'h30);
      idle(4);
      chk("serial swap", 8'h85, pin_out);
      chk("serial in", 4'h2, ser_in);
      ser_oe <= 4'h0;
      t0_en <= 4'h0;
      wr(8'h34, 8'h00);
      for (logic [3:0] c = 4'h0; c < 4'h8; c++) begin
         wr(8'h40, {2'h0, c[2:0], 3'h0});
         for (logic [1:0] l = 2'h0; l < 2'h2; l++) begin
            wr(8'h10, {7'h0, l[0]});
            idle(2);
            oe = !c[2] | (c[0] ^ l[0]);
            chk("pin mode", {oe, oe & l[0], c == 4'h7, c == 4'h6, c == 4'h1},
                {pin_oe[0], pin_out[0] & pin_oe[0], pin_pu[0], pin_pd[0], pin_hold[0]});
         end
      end
      wr(8'h00, 8'h00);
      wr(8'h40, 8'h10);
      idle(2);
      chk("pull on input", 1'b1, pin_pd[0]);
      wr(8'h40, 8'h80);
      idle(2);
      chk("slew", 1'b1, pin_slew[0]);
      wr(8'h00, 8'h01);
      wr(8'h10, 8'h00);
      wr(8'h40, 8'h40);
      idle(2);
      chk("inverted out", 1'b1, pin_out[0]);
      tally_and_finish();
   end
endmodule // gpio_port_regs_remap_test
